/* rtl/gic_cfg.svh */
// register map, reset values and timing counts of the idle clock gating block
// assumes inclusion by bare name from rtl/
`ifndef GIC_CFG_SVH
`define GIC_CFG_SVH

`define GIC_CTRL_OFF 12'h000
`define GIC_STARTUP_OFF 12'h004
`define GIC_TIMEOUT_OFF 12'h008
`define GIC_STATUS_OFF 12'h00C
`define GIC_COUNT_OFF 12'h010

`define GIC_CTRL_EN_BIT 0
`define GIC_CTRL_EN_RST 1'b0
`define GIC_STARTUP_RST 16'h0100
`define GIC_TIMEOUT_RST 16'h0100

`define GIC_SETTLE_NS 200
`define GIC_CLK_MHZ 25
`define GIC_SETTLE_CYC ((`GIC_SETTLE_NS * `GIC_CLK_MHZ + 999) / 1000)

`endif

/* rtl/gic_pkg.sv */
// types shared by the idle clock gating block
// assumes no surroundings
package gic_pkg;
    typedef enum logic [3:0] {
        GIC_MODE_DEEP = 4'h1,
        GIC_MODE_BUS = 4'h2,
        GIC_MODE_2D = 4'h4,
        GIC_MODE_3D = 4'h8
    } gic_mode_t;
    typedef enum logic [3:0] {
        GIC_ST_MON = 4'h1,
        GIC_ST_STARTUP = 4'h2,
        GIC_ST_SETTLE = 4'h4,
        GIC_ST_COUNT = 4'h8
    } gic_state_t;
endpackage

/* rtl/gic_cnt_if.sv */
// carrier between the gating controller and its down-counter
// assumes both ends on pclk
`timescale 1ns/1ns
`default_nettype none
interface gic_cnt_if;
    logic load;
    logic [15:0] load_val;
    logic dec;
    logic zero;
    logic [15:0] value;
    modport ctl (output load, output load_val, output dec, input zero, input value);
    modport cnt (input load, input load_val, input dec, output zero, output value);
endinterface
`default_nettype wire

/* rtl/gic_down_counter.sv */
// loadable down-counter used for the startup and idle time-outs
// assumes synchronous load and decrement requests on pclk
`timescale 1ns/1ns
`default_nettype none
module gic_down_counter (
    input wire logic pclk,
    input wire logic presetn,
    gic_cnt_if.cnt cnt
);
    logic [15:0] value;
    logic [15:0] next_value;

    always_comb begin
        next_value = value;
        if (cnt.load) begin
            next_value = cnt.load_val;
        end else if (cnt.dec && value != 16'h0000) begin
            next_value = value - 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value <= 16'h0000;
        end else begin
            value <= next_value;
        end
    end

    assign cnt.value = value;
    assign cnt.zero = (value == 16'h0000);
endmodule
`default_nettype wire

/* rtl/gic_idle_gate.sv */
// activity-driven clock gating controller for the graphics accelerator
// assumes activity and instruction inputs are synchronous to pclk; APB master drives the bus
//
// Contract
// - the block watches the core activity inputs every cycle except while settling or gated in countdown to judge whether the core is idle.
// - after idleness lasts the startup time-out count the gate requests go high.
// - four gating modes exist: all gated, bus only, bus and 2D, all running.
// - an instruction detected outside settling is decoded and only the clocks it needs are re-enabled.
// - after re-enabling clocks the block waits a settling interval before counting.
// - after settling the counter loads the time-out value and decrements while idle.
// - activity during the countdown reloads the counter to its programmed value.
// - at count end with no activity or pending instruction the clocks are gated again.
`timescale 1ns/1ns
`default_nettype none
`include "gic_cfg.svh"
module gic_idle_gate #(
    parameter int unsigned SETTLE_CYC = `GIC_SETTLE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic core_2d_active,
    input wire logic core_3d_active,
    input wire logic instr_valid,
    input wire logic instr_is_3d,
    output logic gate_bus_side_clock,
    output logic gate_core_2d_clock,
    output logic gate_core_3d_clock
);
    // ************************************************************
    // register bus
    // ************************************************************
    logic enable;
    logic [15:0] startup_cnt;
    logic [15:0] timeout_cnt;
    logic next_enable;
    logic [15:0] next_startup_cnt;
    logic [15:0] next_timeout_cnt;
    logic [31:0] next_prdata;
    logic next_pslverr;
    gic_pkg::gic_state_t state;
    gic_pkg::gic_state_t next_state;
    gic_pkg::gic_mode_t mode;
    gic_pkg::gic_mode_t next_mode;
    gic_cnt_if cif ();

    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == `GIC_CTRL_OFF) || (a == `GIC_STARTUP_OFF) ||
                   (a == `GIC_TIMEOUT_OFF) || (a == `GIC_STATUS_OFF) ||
                   (a == `GIC_COUNT_OFF);
    endfunction

    wire logic wr_req = psel && !penable && pwrite;
    wire logic rd_req = psel && !penable && !pwrite;

    // answer registered in the setup cycle so pready can be held high in access
    always_comb begin
        next_enable = enable;
        next_startup_cnt = startup_cnt;
        next_timeout_cnt = timeout_cnt;
        next_prdata = prdata;
        next_pslverr = 1'b0;
        if (psel && !penable) begin
            next_pslverr = !addr_hit(paddr);
        end
        if (wr_req) begin
            case (paddr)
                `GIC_CTRL_OFF: next_enable = pwdata[`GIC_CTRL_EN_BIT];
                `GIC_STARTUP_OFF: next_startup_cnt = pwdata[15:0];
                `GIC_TIMEOUT_OFF: next_timeout_cnt = pwdata[15:0];
                default: next_enable = enable;
            endcase
        end
        if (rd_req) begin
            case (paddr)
                `GIC_CTRL_OFF: next_prdata = {31'h0, enable};
                `GIC_STARTUP_OFF: next_prdata = {16'h0, startup_cnt};
                `GIC_TIMEOUT_OFF: next_prdata = {16'h0, timeout_cnt};
                `GIC_STATUS_OFF: next_prdata = {24'h0, state, mode};
                `GIC_COUNT_OFF: next_prdata = {16'h0, cif.value};
                default: next_prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable <= `GIC_CTRL_EN_RST;
            startup_cnt <= `GIC_STARTUP_RST;
            timeout_cnt <= `GIC_TIMEOUT_RST;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            enable <= next_enable;
            startup_cnt <= next_startup_cnt;
            timeout_cnt <= next_timeout_cnt;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // no wait states: setup writes, access completes
    assign pready = 1'b1;

    // ************************************************************
    // gating state machine
    // ************************************************************
    logic [7:0] settle;
    logic [7:0] next_settle;
    wire logic activity = core_2d_active || core_3d_active || instr_valid;
    wire logic wake;

    // an instruction needs clocks that are stopped now: 2d gated (deep or bus only), or 3d work in 2d mode
    function automatic logic wake_needed(input gic_pkg::gic_mode_t m, input logic v,
                                         input logic is_3d);
        wake_needed = v && (m == gic_pkg::GIC_MODE_DEEP || m == gic_pkg::GIC_MODE_BUS ||
                            (is_3d && m != gic_pkg::GIC_MODE_3D));
    endfunction

    // wake from deep always opens 2d at least, so bus-only is never a wake target
    function automatic gic_pkg::gic_mode_t wake_mode(input logic is_3d);
        wake_mode = is_3d ? gic_pkg::GIC_MODE_3D : gic_pkg::GIC_MODE_2D;
    endfunction

    assign wake = wake_needed(mode, instr_valid, instr_is_3d);

    always_comb begin
        next_state = state;
        next_mode = mode;
        next_settle = settle;
        cif.load = 1'b0;
        cif.load_val = timeout_cnt;
        cif.dec = 1'b0;
        case (state)
            gic_pkg::GIC_ST_MON: begin
                cif.load = 1'b1;
                cif.load_val = startup_cnt;
                if (enable && !activity) begin
                    next_state = gic_pkg::GIC_ST_STARTUP;
                end
            end
            gic_pkg::GIC_ST_STARTUP: begin
                if (!enable || activity) begin
                    next_state = gic_pkg::GIC_ST_MON;
                end else if (cif.zero) begin
                    next_mode = gic_pkg::GIC_MODE_DEEP;
                    next_state = gic_pkg::GIC_ST_COUNT;
                end else begin
                    cif.dec = 1'b1;
                end
            end
            gic_pkg::GIC_ST_SETTLE: begin
                if (settle == 8'h00) begin
                    cif.load = 1'b1;
                    next_state = gic_pkg::GIC_ST_COUNT;
                end else begin
                    next_settle = settle - 8'h01;
                end
            end
            gic_pkg::GIC_ST_COUNT: begin
                if (mode == gic_pkg::GIC_MODE_DEEP) begin
                    // gated: only an instruction leaves, taken after the case
                    next_state = gic_pkg::GIC_ST_COUNT;
                end else if (activity) begin
                    cif.load = 1'b1;
                end else if (cif.zero || !enable) begin
                    next_mode = gic_pkg::GIC_MODE_DEEP;
                    next_state = gic_pkg::GIC_ST_MON;
                end else begin
                    cif.dec = 1'b1;
                end
            end
            default: next_state = gic_pkg::GIC_ST_MON;
        endcase
        // an instruction wakes the clocks from monitor, startup or countdown alike;
        // settling is never cut short so a waking clock always gets its full interval
        if (wake && state != gic_pkg::GIC_ST_SETTLE) begin
            // release only the needed gates as settling begins
            cif.load = 1'b0;
            cif.dec = 1'b0;
            next_mode = wake_mode(instr_is_3d);
            next_settle = 8'(SETTLE_CYC - 1);
            next_state = gic_pkg::GIC_ST_SETTLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= gic_pkg::GIC_ST_MON;
            mode <= gic_pkg::GIC_MODE_3D;
            settle <= 8'h00;
        end else begin
            state <= next_state;
            mode <= next_mode;
            settle <= next_settle;
        end
    end

    gic_down_counter u_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .cnt(cif)
    );

    // ************************************************************
    // gate requests
    // ************************************************************
    logic next_gate_bus_side_clock;
    logic next_gate_core_2d_clock;
    logic next_gate_core_3d_clock;

    // mode to gate requests {3d, 2d, bus}, high means the clock may stop
    function automatic logic [2:0] gates_for(input gic_pkg::gic_mode_t m);
        gates_for = {m != gic_pkg::GIC_MODE_3D,
                     m == gic_pkg::GIC_MODE_DEEP || m == gic_pkg::GIC_MODE_BUS,
                     m == gic_pkg::GIC_MODE_DEEP};
    endfunction

    // decoded from the next mode and registered: same timing as the mode register,
    // but the wrapper never sees a decode glitch on a request line
    always_comb begin
        {next_gate_core_3d_clock, next_gate_core_2d_clock, next_gate_bus_side_clock} =
            gates_for(next_mode);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_bus_side_clock <= 1'b0;
            gate_core_2d_clock <= 1'b0;
            gate_core_3d_clock <= 1'b0;
        end else begin
            gate_bus_side_clock <= next_gate_bus_side_clock;
            gate_core_2d_clock <= next_gate_core_2d_clock;
            gate_core_3d_clock <= next_gate_core_3d_clock;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    AST_GATE_ON_STARTUP: assert property (@(posedge pclk) disable iff (!presetn)
        state == gic_pkg::GIC_ST_STARTUP && enable && !activity && cif.zero
        |=> gate_bus_side_clock && gate_core_2d_clock && gate_core_3d_clock)
        else $error("gates not raised at startup expiry");
    AST_MODE_LEGAL: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot(mode) && (gate_core_2d_clock || !gate_bus_side_clock))
        else $error("illegal gating mode");
    AST_DECODE_3D: assert property (@(posedge pclk) disable iff (!presetn)
        state == gic_pkg::GIC_ST_COUNT && instr_valid && instr_is_3d
        |=> !gate_core_3d_clock && !gate_core_2d_clock && !gate_bus_side_clock)
        else $error("3d instruction did not open clocks");
    AST_DECODE_2D: assert property (@(posedge pclk) disable iff (!presetn)
        state == gic_pkg::GIC_ST_COUNT && instr_valid && !instr_is_3d &&
        mode == gic_pkg::GIC_MODE_DEEP |=> gate_core_3d_clock && !gate_core_2d_clock)
        else $error("2d instruction opened wrong clocks");
    AST_SETTLE_LEN: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state == gic_pkg::GIC_ST_SETTLE)
        |-> (state == gic_pkg::GIC_ST_SETTLE) [*5] ##1 state == gic_pkg::GIC_ST_COUNT)
        else $error("settling length wrong");
    AST_LOAD_AFTER_SETTLE: assert property (@(posedge pclk) disable iff (!presetn)
        state == gic_pkg::GIC_ST_SETTLE && next_state == gic_pkg::GIC_ST_COUNT
        |=> cif.value == $past(timeout_cnt))
        else $error("countdown not loaded after settling");
    AST_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
        state == gic_pkg::GIC_ST_COUNT && mode != gic_pkg::GIC_MODE_DEEP && activity &&
        next_state == gic_pkg::GIC_ST_COUNT |=> cif.value == $past(timeout_cnt))
        else $error("activity did not reload countdown");
    AST_REGATE: assert property (@(posedge pclk) disable iff (!presetn)
        state == gic_pkg::GIC_ST_COUNT && mode != gic_pkg::GIC_MODE_DEEP && !activity &&
        cif.zero |=> gate_bus_side_clock && state == gic_pkg::GIC_ST_MON)
        else $error("clocks not gated at count end");
    AST_RELEASE_EARLY: assert property (@(posedge pclk) disable iff (!presetn)
        state == gic_pkg::GIC_ST_SETTLE |-> !gate_core_2d_clock && !gate_bus_side_clock)
        else $error("gates still high while settling");
    AST_WAKE_FROM_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        state != gic_pkg::GIC_ST_SETTLE && mode == gic_pkg::GIC_MODE_DEEP && instr_valid
        |=> !gate_bus_side_clock && !gate_core_2d_clock && state == gic_pkg::GIC_ST_SETTLE)
        else $error("instruction did not wake the gated clocks");
    AST_COUNT_DOWN: assert property (@(posedge pclk) disable iff (!presetn)
        state == gic_pkg::GIC_ST_COUNT && mode != gic_pkg::GIC_MODE_DEEP && enable &&
        !activity && !cif.zero |=> cif.value == $past(cif.value) - 16'h0001)
        else $error("countdown did not step while idle");
    AST_DISABLE_REGATE: assert property (@(posedge pclk) disable iff (!presetn)
        state == gic_pkg::GIC_ST_COUNT && mode != gic_pkg::GIC_MODE_DEEP && !enable &&
        !activity |=> gate_bus_side_clock && gate_core_2d_clock && gate_core_3d_clock)
        else $error("clearing enable did not gate the clocks");
    COV_DEEP: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(gate_bus_side_clock));
    COV_WAKE_3D: cover property (@(posedge pclk) disable iff (!presetn)
        $fell(gate_core_3d_clock));
    COV_RELOAD: cover property (@(posedge pclk) disable iff (!presetn)
        state == gic_pkg::GIC_ST_COUNT && activity && mode == gic_pkg::GIC_MODE_2D);
    COV_WAKE_2D: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(mode == gic_pkg::GIC_MODE_2D));
    COV_DISABLE: cover property (@(posedge pclk) disable iff (!presetn)
        state == gic_pkg::GIC_ST_COUNT && !enable && mode != gic_pkg::GIC_MODE_DEEP);
endmodule
`default_nettype wire

/* testbench/gic_wrapper_model.sv */
// behavioural model of the clock gate wrapper on the far side of the gate requests
// assumes gate requests are synchronous to pclk, bit order {3d, 2d, bus}
`timescale 1ns/1ns
`default_nettype none
module gic_wrapper_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] gate_req,
    output logic [2:0] clk_running
);
    // ************************************
    // clock enables
    // ************************************
    // a clock stops or restarts one edge after the request, so no half cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_running <= 3'h7;
        end else begin
            clk_running <= ~gate_req;
        end
    end
endmodule
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench of the idle clock gating controller
// assumes gic_cfg.svh on the include path, pclk at 25 MHz
`timescale 1ns/1ns
`default_nettype none
`include "gic_cfg.svh"
module tb;
    localparam int SETTLE = `GIC_SETTLE_CYC;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic a2d, a3d, iv, i3d;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] g, run;
    int err_count, num_checks, cyc, sc, tc, n, seed;

    gic_idle_gate #(.SETTLE_CYC(SETTLE)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core_2d_active(a2d), .core_3d_active(a3d),
        .instr_valid(iv), .instr_is_3d(i3d), .gate_bus_side_clock(g[0]),
        .gate_core_2d_clock(g[1]), .gate_core_3d_clock(g[2]));
    gic_wrapper_model wrap (.pclk(pclk), .presetn(presetn), .gate_req(g), .clk_running(run));

    // ************************************
    // reference model and helpers
    // ************************************
    // mode codes: 1 deep, 2 bus only, 4 bus and 2d, 8 all running
    function automatic logic [2:0] gates_of(input int m);
        return (m == 1) ? 3'h7 : (m == 2) ? 3'h6 : (m == 4) ? 3'h4 : 3'h0;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(rd, x);
    endtask

    // counts cycles until every clock may stop
    task automatic wait_g();
        n = 0;
        while (g !== 3'h7 && n < 3000) begin
            @(negedge pclk);
            n++;
        end
    endtask

    // ************************************
    // clock, timeout and main sequence
    // ************************************
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, a2d, a3d, iv, i3d} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        err_count = 0;
        num_checks = 0;
        cyc = 0;
        seed = $urandom(30007);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`GIC_CTRL_OFF, 32'h0);
        rdc(`GIC_STARTUP_OFF, 32'h0000_0100);
        rdc(`GIC_TIMEOUT_OFF, 32'h0000_0100);
        rdc(`GIC_STATUS_OFF, 32'h0000_0018);
        chk(g, gates_of(8));
        apb(1'b0, 12'h0FC, 32'h0);
        chk({rd[30:0], e}, 32'h1);
        sc = 8 + ($urandom % 32);
        tc = 8 + ($urandom % 32);
        apb(1'b1, `GIC_STARTUP_OFF, sc);
        apb(1'b1, `GIC_TIMEOUT_OFF, tc);
        a3d <= 1'b1;
        apb(1'b1, `GIC_CTRL_OFF, 32'h1);
        repeat (sc + 10) @(negedge pclk);
        chk(g, gates_of(8));
        @(posedge pclk);
        a3d <= 1'b0;
        wait_g();
        chk(n >= sc && n <= sc + 4, 1);
        rdc(`GIC_STATUS_OFF, 32'h0000_0081);
        chk(run, 3'h0);
        for (int k = 0; k < 2; k++) begin
            @(posedge pclk);
            iv <= 1'b1;
            i3d <= k[0];
            @(posedge pclk);
            iv <= 1'b0;
            a2d <= k[0];
            @(negedge pclk);
            chk(g, gates_of(k ? 8 : 4));
            if (k == 1) begin
                // busy core must keep the countdown topped up
                repeat (SETTLE + tc + 10) @(negedge pclk);
                chk(g, gates_of(8));
                rdc(`GIC_COUNT_OFF, tc);
                rdc(`GIC_STATUS_OFF, 32'h0000_0088);
                @(posedge pclk);
                a2d <= 1'b0;
                wait_g();
                chk(n >= tc && n <= tc + 4, 1);
            end else begin
                // the wrapper follows a request one edge later
                @(negedge pclk);
                chk(run, 3'h3);
                wait_g();
                chk(n >= SETTLE + tc - 1 && n <= SETTLE + tc + 4, 1);
            end
            // through monitor and into startup, already counting the startup time-out again
            rdc(`GIC_STATUS_OFF, 32'h0000_0021);
        end
        // clearing enable while settling gates as soon as the countdown starts and holds the monitor
        @(posedge pclk);
        iv <= 1'b1;
        i3d <= 1'b1;
        @(posedge pclk);
        iv <= 1'b0;
        apb(1'b1, `GIC_CTRL_OFF, 32'h0);
        wait_g();
        chk(n >= 1 && n <= SETTLE + 2, 1);
        rdc(`GIC_STATUS_OFF, 32'h0000_0011);
        give_verdict();
    end
endmodule
`default_nettype wire
